// file: sup_pkg.sv
package sup_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned HB_US         = 500;
  localparam int unsigned HB_CYC        = CLK_HZ / 1_000_000 * HB_US;
  localparam int unsigned SAMPLE_US     = 33_333;
  localparam int unsigned SAMPLE_CYC    = CLK_HZ / 1_000_000 * SAMPLE_US;
  // Countdown lengths in ms, converted to 100 ms ticks
  localparam int unsigned FHALT_MS      = 5000;
  localparam int unsigned PIN_MS        = 1000;
  localparam int unsigned RETRY_MS      = 25_000;
  localparam int unsigned BLK_PROX_MS   = 2000;
  localparam int unsigned BLK_MOVE_MS   = 2000;
  localparam int unsigned SEC_MS        = 1000;
  localparam logic [7:0]  FHALT_TICKS   = 8'(FHALT_MS / TICK_MS);
  localparam logic [7:0]  PIN_TICKS     = 8'(PIN_MS / TICK_MS);
  localparam logic [7:0]  RETRY_TICKS   = 8'(RETRY_MS / TICK_MS);
  localparam logic [7:0]  BLK_PROX_TICKS = 8'(BLK_PROX_MS / TICK_MS);
  localparam logic [7:0]  BLK_MOVE_TICKS = 8'(BLK_MOVE_MS / TICK_MS);
  localparam logic [7:0]  TICKS_PER_S   = 8'(SEC_MS / TICK_MS);
  // Register offsets
  localparam logic [7:0]  ADDR_CMD      = 8'h04;
  localparam logic [7:0]  ADDR_HOLD_H   = 8'h25;
  localparam logic [7:0]  ADDR_HOLD_L   = 8'h26;
  localparam logic [7:0]  ADDR_FHALT    = 8'h27;
  localparam logic [7:0]  ADDR_PIN      = 8'h28;
  localparam logic [7:0]  ADDR_RETRY    = 8'h29;
  localparam logic [7:0]  ADDR_CFG      = 8'h30;
  localparam logic [7:0]  ADDR_HOLDSET  = 8'h31;
  localparam logic [7:0]  ADDR_STAT     = 8'h32;
  // Command bits
  localparam int unsigned CMD_STANDALONE = 0;
  localparam int unsigned CMD_AUTOCAL    = 1;
  localparam int unsigned CMD_SENSE_OFF  = 5;
  localparam int unsigned CMD_SENSE_ON   = 6;
  localparam int unsigned CMD_RECAL      = 7;
  // Configuration fields
  localparam int unsigned CFG_UI_LO     = 0;
  localparam int unsigned CFG_UI_HI     = 1;
  localparam int unsigned CFG_HALT      = 2;
  localparam int unsigned CFG_HB        = 3;
  localparam int unsigned CFG_QR        = 4;
  localparam int unsigned CFG_HH        = 5;
  localparam int unsigned CFG_COMP      = 6;
  localparam int unsigned CFG_BURST     = 7;
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [7:0]  HOLDSET_RST   = 8'h3c;
  // Interface behaviour modes
  localparam logic [1:0]  UI_PROX       = 2'h0;
  localparam logic [1:0]  UI_PROX_MOVE  = 2'h1;
  localparam logic [1:0]  UI_PROX_TOUCH = 2'h2;

  typedef enum logic [1:0] {SUP_IDLE, SUP_WAIT_SYNC, SUP_BEAT, SUP_CONV} sup_state_t;
endpackage

// file: sup_cnt_if.sv
`timescale 1ns/1ns
`default_nettype none
// Control and value of one saturating countdown
interface sup_cnt_if #(parameter int W = 8);
  logic         tick;
  logic         load;
  logic [W-1:0] load_val;
  logic [W-1:0] value;
  logic         zero;
  modport owner (output tick, output load, output load_val, input value, input zero);
  modport timer (input tick, input load, input load_val, output value, output zero);
endinterface
`default_nettype wire

// file: sup_countdown.sv
`timescale 1ns/1ns
`default_nettype none
module sup_countdown #(
  parameter int W = 8
) (
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  sup_cnt_if.timer   cnt
);
  logic [W-1:0] value_r;

  // Load wins over a tick; stops at zero instead of wrapping
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      value_r <= '0;
    end else if (cnt.load) begin
      value_r <= cnt.load_val;
    end else if (cnt.tick && value_r != '0) begin
      value_r <= value_r - W'(1);
    end
  end

  assign cnt.value = value_r;
  assign cnt.zero  = (value_r == '0);
endmodule
`default_nettype wire

// file: sup_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Filter-halt five second countdown before proximity
// - Pin sample countdown, ten 100 ms steps
// - Retry calibration after 25 s countdown
// - 500 us heartbeat per sensing event
// - Heartbeat precedes conversion start
// - Heartbeat repeats for every burst conversion
// - Heartbeat off at reset, strap or config
// - Quick release watches proximity channel slope
// - Release event held only while proximity holds
// - Two channels share electrode, own slots
// - Block time per channel suppresses recalibration
// - Compensation tracks only without proximity trigger
// - Three selectable interface behaviour modes
// - Handheld or quick release force movement timeout
// - Standalone command stops serial register writes; reads are still answered
// - Sense only in windows granted by sync
// - Command bit seven starts proximity recalibration
// - Proximity output asserted during proximity calibration or its error
module sup_supervisor
  import sup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES   = TICK_CYC,
  parameter int unsigned HB_CYCLES     = HB_CYC,
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int unsigned BURST_LEN     = 4
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            serial_en,
  input  wire logic       otp_hb_en,
  input  wire logic       sync_pin,
  input  wire logic       sampled_input_pin,
  output logic            heartbeat_output_pin,
  output logic            conv_start,
  output logic            conv_ch,
  input  wire logic       conv_done,
  input  wire logic       prox_raw,
  input  wire logic       touch_raw,
  input  wire logic       movement_evt,
  input  wire logic       prox_slope_fall,
  input  wire logic       prox_oob,
  input  wire logic       move_oob,
  output logic            cal_start,
  output logic            cal_ch,
  input  wire logic       cal_done,
  input  wire logic       cal_err,
  output logic            prox_out,
  output logic            quick_release,
  output logic            track_en,
  output logic            move_sense_en,
  output logic            timeout_en
);
  logic [7:0]  cfg_r, holdset_r;
  logic        standalone_r, sense_en_r, autocal_r, strap_done_r, hb_en_r;
  logic        sync_meta_r, sync_r, pin_meta_r, pin_r, pin_val_r;
  logic [22:0] tick_cnt_r;
  logic [22:0] smp_cnt_r;
  logic [15:0] hb_cnt_r;
  logic        tick, sample_due;
  logic [7:0]  burst_left_r;
  logic        slot_r, raw_d_r, prox_decl_r, qr_r, hold_exp_r;
  logic        cal_busy_r, cal_err_r, prox_req_r, move_req_r, retry_armed_r;
  logic        cmd_wr;
  logic [1:0]  ui_mode;
  sup_state_t  state_r, state_nxt;

  sup_cnt_if #(.W(16)) hold_if ();
  sup_cnt_if #(.W(8))  fh_if ();
  sup_cnt_if #(.W(8))  pin_if ();
  sup_cnt_if #(.W(8))  retry_if ();
  sup_cnt_if #(.W(8))  bp_if ();
  sup_cnt_if #(.W(8))  bm_if ();

  sup_countdown #(.W(16)) u_hold  (.mclk(mclk), .sys_rst(sys_rst), .cnt(hold_if));
  sup_countdown #(.W(8))  u_fh    (.mclk(mclk), .sys_rst(sys_rst), .cnt(fh_if));
  sup_countdown #(.W(8))  u_pin   (.mclk(mclk), .sys_rst(sys_rst), .cnt(pin_if));
  sup_countdown #(.W(8))  u_retry (.mclk(mclk), .sys_rst(sys_rst), .cnt(retry_if));
  sup_countdown #(.W(8))  u_bp    (.mclk(mclk), .sys_rst(sys_rst), .cnt(bp_if));
  sup_countdown #(.W(8))  u_bm    (.mclk(mclk), .sys_rst(sys_rst), .cnt(bm_if));

  // Pins from outside pass two flops before use
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_meta_r <= 1'b1;
      sync_r      <= 1'b1;
      pin_meta_r  <= 1'b0;
      pin_r       <= 1'b0;
    end else begin
      sync_meta_r <= sync_pin;
      sync_r      <= sync_meta_r;
      pin_meta_r  <= sampled_input_pin;
      pin_r       <= pin_meta_r;
    end
  end

  // 100 ms tick and sample-rate strobe
  assign tick       = (tick_cnt_r == 23'(TICK_CYCLES - 1));
  assign sample_due = (smp_cnt_r == 23'(SAMPLE_CYCLES - 1));
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
      smp_cnt_r  <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 23'h1;
      smp_cnt_r  <= sample_due ? '0 : smp_cnt_r + 23'h1;
    end
  end

  // Register writes; serial side goes quiet once standalone
  assign cmd_wr    = reg_wr && serial_en && reg_addr == ADDR_CMD;
  assign serial_en = !standalone_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_r        <= CFG_RST;
      holdset_r    <= HOLDSET_RST;
      standalone_r <= 1'b0;
      sense_en_r   <= 1'b1;
      autocal_r    <= 1'b1;
    end else if (reg_wr && serial_en) begin
      if (reg_addr == ADDR_CFG) cfg_r <= reg_wdata;
      if (reg_addr == ADDR_HOLDSET) holdset_r <= reg_wdata;
      if (cmd_wr) begin
        if (reg_wdata[CMD_STANDALONE]) standalone_r <= 1'b1;
        if (reg_wdata[CMD_AUTOCAL]) autocal_r <= !autocal_r;
        if (reg_wdata[CMD_SENSE_OFF]) sense_en_r <= 1'b0;
        if (reg_wdata[CMD_SENSE_ON]) sense_en_r <= 1'b1;
      end
    end
  end

  // Heartbeat enable: strap caught after reset, or config before standalone
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strap_done_r <= 1'b0;
      hb_en_r      <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
      if (!strap_done_r) hb_en_r <= otp_hb_en;
      else if (reg_wr && serial_en && reg_addr == ADDR_CFG) hb_en_r <= reg_wdata[CFG_HB];
    end
  end

  // Readback registered; unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_HOLD_H:  reg_rdata <= hold_if.value[15:8];
        ADDR_HOLD_L:  reg_rdata <= hold_if.value[7:0];
        ADDR_FHALT:   reg_rdata <= fh_if.value;
        ADDR_PIN:     reg_rdata <= pin_if.value;
        ADDR_RETRY:   reg_rdata <= retry_if.value;
        ADDR_CFG:     reg_rdata <= {cfg_r[CFG_BURST:CFG_QR], hb_en_r, cfg_r[CFG_HALT:CFG_UI_LO]};
        ADDR_HOLDSET: reg_rdata <= holdset_r;
        ADDR_STAT:    reg_rdata <= {sense_en_r, pin_val_r, hold_exp_r, cal_busy_r,
                                    cal_err_r, qr_r, autocal_r, prox_out};
        default:      reg_rdata <= 8'h00;
      endcase
    end
  end

  // Sensing sequence: grant window, heartbeat, then conversion
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SUP_IDLE:      if (sample_due && sense_en_r) state_nxt = SUP_WAIT_SYNC;
      SUP_WAIT_SYNC: if (!sync_r) state_nxt = hb_en_r ? SUP_BEAT : SUP_CONV;
      SUP_BEAT:      if (hb_cnt_r == 16'h0) state_nxt = SUP_CONV;
      SUP_CONV: begin
        if (conv_done) state_nxt = (burst_left_r != 8'h0) ? SUP_WAIT_SYNC : SUP_IDLE;
      end
      default:       state_nxt = SUP_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) state_r <= SUP_IDLE;
    else         state_r <= state_nxt;
  end

  // Heartbeat pulse timing and pin drive
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hb_cnt_r             <= '0;
      heartbeat_output_pin <= 1'b0;
    end else begin
      if (state_r != SUP_BEAT && state_nxt == SUP_BEAT) hb_cnt_r <= 16'(HB_CYCLES - 1);
      else if (hb_cnt_r != 16'h0) hb_cnt_r <= hb_cnt_r - 16'h1;
      heartbeat_output_pin <= (state_nxt == SUP_BEAT);
    end
  end

  // Conversion strobe, burst count and alternating channel slots
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      conv_start   <= 1'b0;
      burst_left_r <= 8'h0;
      slot_r       <= 1'b0;
    end else begin
      conv_start <= (state_r != SUP_CONV && state_nxt == SUP_CONV);
      if (state_r == SUP_IDLE && state_nxt == SUP_WAIT_SYNC) begin
        burst_left_r <= cfg_r[CFG_BURST] ? 8'(BURST_LEN - 1) : 8'h0;
      end else if (state_r == SUP_CONV && conv_done) begin
        if (burst_left_r != 8'h0) burst_left_r <= burst_left_r - 8'h1;
        else slot_r <= !slot_r;
      end
    end
  end
  assign conv_ch = slot_r;

  // Mode decode
  assign ui_mode       = cfg_r[CFG_UI_HI:CFG_UI_LO];
  assign move_sense_en = cfg_r[CFG_HH] || cfg_r[CFG_QR] || (ui_mode == UI_PROX_MOVE) ||
                         (ui_mode == UI_PROX_TOUCH && prox_decl_r && !touch_raw);
  assign timeout_en    = move_sense_en && !(ui_mode == UI_PROX_TOUCH && touch_raw &&
                         !cfg_r[CFG_HH] && !cfg_r[CFG_QR]);
  assign track_en      = cfg_r[CFG_COMP] && !prox_raw && !prox_decl_r;

  // Countdown hookups
  assign hold_if.tick     = tick && timeout_en;
  assign hold_if.load     = movement_evt;
  assign hold_if.load_val = 16'(holdset_r) * 16'(TICKS_PER_S);
  assign fh_if.tick       = tick && prox_raw;
  assign fh_if.load       = prox_raw && !raw_d_r && cfg_r[CFG_HALT];
  assign fh_if.load_val   = FHALT_TICKS;
  assign pin_if.tick      = tick;
  assign pin_if.load      = tick && pin_if.zero;
  assign pin_if.load_val  = PIN_TICKS;
  assign retry_if.tick    = tick;
  assign retry_if.load    = cal_busy_r && cal_done && !cal_ch && cal_err;
  assign retry_if.load_val = RETRY_TICKS;
  assign bp_if.tick       = tick;
  assign bp_if.load       = cal_busy_r && cal_done && !cal_ch;
  assign bp_if.load_val   = BLK_PROX_TICKS;
  assign bm_if.tick       = tick;
  assign bm_if.load       = cal_busy_r && cal_done && cal_ch;
  assign bm_if.load_val   = BLK_MOVE_TICKS;

  // Proximity declaration, pin sample, hold expiry, quick release
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      raw_d_r     <= 1'b0;
      prox_decl_r <= 1'b0;
      pin_val_r   <= 1'b0;
      hold_exp_r  <= 1'b0;
      qr_r        <= 1'b0;
    end else begin
      raw_d_r     <= prox_raw;
      prox_decl_r <= prox_raw && raw_d_r && (!cfg_r[CFG_HALT] || fh_if.zero);
      if (pin_if.load) pin_val_r <= pin_r;
      hold_exp_r  <= timeout_en && prox_decl_r && hold_if.zero && !movement_evt;
      // Event latched from slope, dropped as soon as proximity ends
      if (!prox_decl_r) qr_r <= 1'b0;
      else if (cfg_r[CFG_QR] && prox_slope_fall) qr_r <= 1'b1;
    end
  end
  assign quick_release = qr_r;

  // Calibration requests; a new request wins over the clear at start
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prox_req_r    <= 1'b1;
      move_req_r    <= 1'b0;
      retry_armed_r <= 1'b0;
    end else begin
      if (cal_start && !cal_ch) prox_req_r <= 1'b0;
      if (cal_start && cal_ch) move_req_r <= 1'b0;
      if (cmd_wr && reg_wdata[CMD_RECAL]) prox_req_r <= 1'b1;
      if (autocal_r && prox_oob && bp_if.zero) prox_req_r <= 1'b1;
      if (autocal_r && move_sense_en && move_oob && bm_if.zero) move_req_r <= 1'b1;
      if (retry_if.load) retry_armed_r <= 1'b1;
      else if (retry_armed_r && retry_if.zero) begin
        retry_armed_r <= 1'b0;
        prox_req_r    <= 1'b1;
      end
    end
  end

  // One calibration at a time, started between sensing events
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cal_start  <= 1'b0;
      cal_ch     <= 1'b0;
      cal_busy_r <= 1'b0;
      cal_err_r  <= 1'b0;
    end else begin
      cal_start <= 1'b0;
      if (!cal_busy_r && !cal_start && state_r == SUP_IDLE && (prox_req_r || move_req_r)) begin
        cal_start  <= 1'b1;
        cal_ch     <= !prox_req_r;
        cal_busy_r <= 1'b1;
      end else if (cal_busy_r && cal_done) begin
        cal_busy_r <= 1'b0;
        if (!cal_ch) cal_err_r <= cal_err;
      end
    end
  end

  // Safe state during proximity calibration and after its error
  assign prox_out = prox_decl_r || cal_err_r || (cal_busy_r && !cal_ch);
endmodule
`default_nettype wire

// file: sup_sva.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks on the supervisor
module sup_sva
  import sup_pkg::*;
#(
  parameter int unsigned HB_CYCLES = HB_CYC
) (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       serial_en,
  input wire logic       sync_pin,
  input wire logic       heartbeat_output_pin,
  input wire logic       conv_start,
  input wire logic       prox_slope_fall,
  input wire logic       cal_start,
  input wire logic       cal_ch,
  input wire logic       prox_out,
  input wire logic       quick_release,
  input wire logic       track_en,
  input wire logic       move_sense_en,
  input wire logic       timeout_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [7:0]  cfg_r;
  logic [15:0] hb_len_r;
  logic [3:0]  sync_hi_r;
  // Shadow of the config register, frozen once the bus is off
  always_ff @(posedge mclk) begin
    if (sys_rst) cfg_r <= CFG_RST;
    else if (reg_wr && serial_en && reg_addr == ADDR_CFG) cfg_r <= reg_wdata;
  end
  // Width of the beat in progress
  always_ff @(posedge mclk) begin
    if (sys_rst || !heartbeat_output_pin) hb_len_r <= 16'h0000;
    else hb_len_r <= hb_len_r + 16'h0001;
  end
  // How long the window has been shut; saturates so it never wraps
  always_ff @(posedge mclk) begin
    if (sys_rst || !sync_pin) sync_hi_r <= 4'h0;
    else if (sync_hi_r != 4'hf) sync_hi_r <= sync_hi_r + 4'h1;
  end
  sequence s_recal_wr;
    reg_wr && serial_en && reg_addr == ADDR_CMD && reg_wdata[CMD_RECAL];
  endsequence
  sequence s_prox_cal;
    cal_start && !cal_ch;
  endsequence
  sequence s_alone_wr;
    reg_wr && serial_en && reg_addr == ADDR_CMD && reg_wdata[CMD_STANDALONE];
  endsequence
  property p_hb_width;
    $fell(heartbeat_output_pin) |-> hb_len_r == HB_CYCLES;
  endproperty
  a_hb_width: assert property (p_hb_width) else $error("beat width wrong");
  property p_conv_after_hb;
    $fell(heartbeat_output_pin) |-> ##[0:1] conv_start;
  endproperty
  a_conv_after_hb: assert property (p_conv_after_hb) else $error("no conversion after beat");
  property p_sync_window;
    $rose(heartbeat_output_pin) |-> sync_hi_r < 4'h5;
  endproperty
  a_sync_window: assert property (p_sync_window) else $error("beat outside window");
  property p_recal;
    s_recal_wr |-> ##[1:1000] s_prox_cal;
  endproperty
  a_recal: assert property (p_recal) else $error("recalibration not started");
  property p_cal_safe;
    s_prox_cal |=> prox_out [*8];
  endproperty
  a_cal_safe: assert property (p_cal_safe) else $error("output low during calibration");
  property p_standalone;
    s_alone_wr |-> ##[1:2] !serial_en ##1 !serial_en [*8];
  endproperty
  a_standalone: assert property (p_standalone) else $error("bus not switched off");
  property p_refused;
    reg_wr && !serial_en && reg_addr == ADDR_CMD && reg_wdata[CMD_RECAL] |=> !cal_start [*4];
  endproperty
  a_refused: assert property (p_refused) else $error("write taken after standalone");
  property p_qr_cause;
    $rose(quick_release) |-> $past(prox_slope_fall) || $past(prox_slope_fall, 2);
  endproperty
  a_qr_cause: assert property (p_qr_cause) else $error("release without slope");
  property p_qr_hold;
    quick_release && !prox_out |-> ##[0:1] !quick_release;
  endproperty
  a_qr_hold: assert property (p_qr_hold) else $error("release outlived proximity");
  property p_track;
    $rose(quick_release) |-> !track_en;
  endproperty
  a_track: assert property (p_track) else $error("tracking during trigger");
  property p_mode_move;
    cfg_r[1:0] == UI_PROX_MOVE |-> move_sense_en;
  endproperty
  a_mode_move: assert property (p_mode_move) else $error("movement mode not sensing");
  property p_force_move;
    cfg_r[CFG_QR] || cfg_r[CFG_HH] |-> move_sense_en && timeout_en;
  endproperty
  a_force_move: assert property (p_force_move) else $error("timeout not forced on");
endmodule
`default_nettype wire

// file: sup_host.sv
`timescale 1ns/1ns
`default_nettype none
// Host model: grants sensing windows and watches the heartbeat
module sup_host #(
  parameter int unsigned LOST_CYCLES = 600
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        sync_hold,
  input  wire logic        heartbeat_output_pin,
  output logic             sync_pin,
  output logic [15:0]      beat_cnt,
  output logic             hb_lost
);
  logic [5:0]  win_r = 6'h00;
  logic        hb_q_r = 1'b0;
  logic [15:0] quiet_r = 16'h0000;
  // Window open 40 of every 64 cycles unless the host holds it shut
  always @(posedge mclk) win_r <= sys_rst ? 6'h00 : win_r + 6'h01;
  assign sync_pin = sync_hold || (win_r >= 6'h28);
  // Beats counted at rising edge; long silence means defaults returned
  always @(posedge mclk) begin
    hb_q_r  <= heartbeat_output_pin;
    quiet_r <= (sys_rst || heartbeat_output_pin) ? 16'h0000 : quiet_r + 16'h0001;
    if (sys_rst) beat_cnt <= 16'h0000;
    else if (heartbeat_output_pin && !hb_q_r) beat_cnt <= beat_cnt + 16'h0001;
  end
  assign hb_lost = (quiet_r >= LOST_CYCLES);
endmodule
`default_nettype wire

// file: sup_supervisor_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module sup_supervisor_bench;
  import sup_pkg::*;
  localparam int unsigned TK = 50;
  logic        mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        otp_hb_en = 1'b0, sampled_input_pin = 1'b0, conv_done = 1'b0, cal_done = 1'b0;
  logic        prox_raw = 1'b0, touch_raw = 1'b0, movement_evt = 1'b0, prox_slope_fall = 1'b0;
  logic        prox_oob = 1'b0, move_oob = 1'b0, cal_err = 1'b0, err_mode = 1'b0;
  logic        sync_hold = 1'b0, sync_pin, hb_lost, serial_en, heartbeat_output_pin;
  logic        conv_start, conv_ch, cal_start, cal_ch, prox_out, quick_release;
  logic        track_en, move_sense_en, timeout_en;
  logic [11:0] cal_sr = 12'h000;
  logic [15:0] n_conv = 16'h0000, n_cal = 16'h0000, beat_cnt, nb, nc, note;
  logic [15:0] exp_q[$];
  int          err_count = 0, checks_done = 0, cyc = 0, seed = 32'hd4c1;
  sup_supervisor #(.TICK_CYCLES(TK), .HB_CYCLES(10), .SAMPLE_CYCLES(100), .BURST_LEN(4))
    sup_supervisor_inst (.mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_en(serial_en),
    .otp_hb_en(otp_hb_en), .sync_pin(sync_pin), .sampled_input_pin(sampled_input_pin),
    .heartbeat_output_pin(heartbeat_output_pin), .conv_start(conv_start), .conv_ch(conv_ch),
    .conv_done(conv_done), .prox_raw(prox_raw), .touch_raw(touch_raw),
    .movement_evt(movement_evt), .prox_slope_fall(prox_slope_fall), .prox_oob(prox_oob),
    .move_oob(move_oob), .cal_start(cal_start), .cal_ch(cal_ch), .cal_done(cal_done),
    .cal_err(cal_err), .prox_out(prox_out), .quick_release(quick_release),
    .track_en(track_en), .move_sense_en(move_sense_en), .timeout_en(timeout_en));
  sup_host sup_host_inst (.mclk(mclk), .sys_rst(sys_rst), .sync_hold(sync_hold),
    .heartbeat_output_pin(heartbeat_output_pin), .sync_pin(sync_pin), .beat_cnt(beat_cnt),
    .hb_lost(hb_lost));
  always #10 mclk = ~mclk;
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  // Reads note the accepted range; countdowns may tick while in flight
  task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({lo, hi});
    @(posedge mclk);
    reg_rd   <= 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Front end answers, event counts and the run limit
  always @(posedge mclk) begin
    cal_sr            <= {cal_sr[10:0], cal_start};
    cal_done          <= cal_sr[11];
    cal_err           <= err_mode;
    conv_done         <= conv_start;
    n_conv            <= n_conv + 16'(conv_start);
    n_cal             <= n_cal + 16'(cal_start);
    rd_q              <= reg_rd;
    sampled_input_pin <= 1'($random(seed));
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end
  // Each answered read retires the oldest note
  always @(negedge mclk) begin
    if (rd_q) begin
      note = exp_q.pop_front();
      `CHK("reg_rdata", note[15:8],
        (reg_rdata >= note[15:8] && reg_rdata <= note[7:0]) ? note[15:8] : reg_rdata)
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    wait_cyc(20);
    `CHK("serial_en", 1'b1, serial_en)
    wr(ADDR_CMD, 8'h40);
    rd(8'hff, 8'h00, 8'h00);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CFG, 8'(m));
      rd(ADDR_CFG, 8'(m), 8'(m));
      wait_cyc(1);
      `CHK("move_sense_en", (m == 1), move_sense_en)
    end
    wr(ADDR_CFG, 8'h20);
    wait_cyc(1);
    `CHK("timeout_en", 1'b1, move_sense_en & timeout_en)
    wr(ADDR_HOLDSET, 8'h02);
    wr(ADDR_CFG, 8'h11);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) movement_evt <= 1'b1;
      @(posedge mclk) movement_evt <= 1'b0;
      rd(ADDR_HOLD_L, 8'h13, 8'h14);
      rd(ADDR_HOLD_H, 8'h00, 8'h00);
      wait_cyc(5 * TK);
      rd(ADDR_HOLD_L, 8'h0e, 8'h10);
    end
    wr(ADDR_CFG, 8'h54);
    prox_raw <= 1'b1;
    rd(ADDR_FHALT, 8'h31, 8'h32);
    wait_cyc(30 * TK);
    `CHK("prox_out", 1'b0, prox_out)
    wait_cyc(25 * TK);
    `CHK("prox_out", 1'b1, prox_out)
    wr(ADDR_FHALT, 8'($random(seed)));
    rd(ADDR_FHALT, 8'h00, 8'h00);
    @(posedge mclk) prox_slope_fall <= 1'b1;
    @(posedge mclk) prox_slope_fall <= 1'b0;
    wait_cyc(3);
    `CHK("quick_release", 1'b1, quick_release)
    `CHK("track_en", 1'b0, track_en)
    @(posedge mclk) prox_raw <= 1'b0;
    wait_cyc(3);
    `CHK("quick_release", 1'b0, quick_release)
    for (int i = 0; i < 4; i++) begin
      wait_cyc(7 * TK + i);
      rd(ADDR_PIN, 8'h00, PIN_TICKS);
    end
    `CHK("beats_off", 16'h0000, beat_cnt)
    wr(ADDR_CFG, 8'h88);
    wr(ADDR_CMD, 8'h20);
    wait_cyc(200);
    nb = beat_cnt;
    nc = n_conv;
    wr(ADDR_CMD, 8'h40);
    wait_cyc(3000);
    wr(ADDR_CMD, 8'h20);
    wait_cyc(200);
    `CHK("beats", n_conv - nc, beat_cnt - nb)
    `CHK("beats_seen", 1'b1, beat_cnt > nb)
    sync_hold <= 1'b1;
    nc = n_conv;
    wr(ADDR_CMD, 8'h40);
    wait_cyc(1000);
    `CHK("conv_blocked", nc, n_conv)
    `CHK("hb_lost", 1'b1, hb_lost)
    @(posedge mclk) sync_hold <= 1'b0;
    wait_cyc(300);
    `CHK("conv_resumed", 1'b1, n_conv != nc)
    `CHK("hb_lost", 1'b0, hb_lost)
    err_mode <= 1'b1;
    nc = n_cal;
    wr(ADDR_CMD, 8'h80);
    wait_cyc(100);
    err_mode <= 1'b0;
    `CHK("cal_count", nc + 16'h0001, n_cal)
    `CHK("prox_out", 1'b1, prox_out)
    rd(ADDR_RETRY, 8'hf6, 8'hfa);
    wait_cyc(252 * TK);
    `CHK("cal_count", nc + 16'h0002, n_cal)
    wr(ADDR_RETRY, 8'($random(seed)));
    rd(ADDR_RETRY, 8'h00, 8'h00);
    wr(ADDR_CMD, 8'h01);
    wait_cyc(2);
    `CHK("serial_en", 1'b0, serial_en)
    nc = n_cal;
    wr(ADDR_CMD, 8'h80);
    wait_cyc(20);
    `CHK("cal_count", nc, n_cal)
    // Mid-run reset: defaults return, the strap now turns the beat on
    @(posedge mclk) sys_rst <= 1'b1;
    otp_hb_en <= 1'b1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    wait_cyc(3);
    `CHK("serial_en", 1'b1, serial_en)
    rd(ADDR_CFG, 8'h08, 8'h08);
    wait_cyc(300);
    `CHK("beats_strap", 1'b1, beat_cnt != 16'h0000)
    // Reference drifts out right after the reset calibration; block time holds it off
    nc = n_cal;
    @(posedge mclk) prox_oob <= 1'b1;
    wait_cyc(400);
    `CHK("cal_blocked", nc, n_cal)
    wait_cyc(900);
    `CHK("cal_unblocked", 1'b1, n_cal != nc)
    close_out();
  end
endmodule
bind sup_supervisor sup_sva #(.HB_CYCLES(HB_CYCLES)) sup_sva_inst (.mclk(mclk),
  .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .serial_en(serial_en), .sync_pin(sync_pin), .heartbeat_output_pin(heartbeat_output_pin),
  .conv_start(conv_start), .prox_slope_fall(prox_slope_fall), .cal_start(cal_start),
  .cal_ch(cal_ch), .prox_out(prox_out), .quick_release(quick_release),
  .track_en(track_en), .move_sense_en(move_sense_en), .timeout_en(timeout_en));
`default_nettype wire
